// ### ncl_pkg.sv
// Shared constants and types for the nonvolatile configuration loader.
package ncl_pkg;

    localparam int NCL_DATA_W = 16;
    localparam int NCL_CFG_WORDS = 16;
    localparam int NCL_ADDR_W = 5;
    localparam int NCL_IDX_W = 4;
    localparam int NCL_USER_PAGES = 2;
    localparam int NCL_PAGE_W = 1;
    localparam int NCL_BUS_ADDR_W = 7;
    localparam int NCL_ASEL_W = 3;

    localparam logic [NCL_BUS_ADDR_W-1:0] NCL_GLOBAL_ADDR = 7'h5B;
    localparam logic [NCL_BUS_ADDR_W-NCL_ASEL_W-1:0] NCL_BASE_ADDR_HI = 4'h4;
    localparam logic [NCL_ADDR_W-1:0] NCL_CRC_NVM_ADDR = 5'h10;
    localparam logic [NCL_ADDR_W-1:0] NCL_IDX_ZERO = 5'h00;
    localparam logic [NCL_ADDR_W-1:0] NCL_IDX_STEP = 5'h01;
    localparam logic [NCL_DATA_W-1:0] NCL_CRC_POLY = 16'h1021;
    localparam logic [NCL_DATA_W-1:0] NCL_CRC_INIT = 16'hFFFF;
    localparam logic [NCL_DATA_W-1:0] NCL_WORD_ZERO = 16'h0000;

    typedef enum logic [5:0] {
        NCL_LD_REQ  = 6'h01,
        NCL_LD_WAIT = 6'h02,
        NCL_LD_CAP  = 6'h04,
        NCL_ST_WR   = 6'h08,
        NCL_RUN     = 6'h10,
        NCL_SPARE   = 6'h20
    } ncl_state_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [NCL_ADDR_W-1:0] addr;
        logic [NCL_DATA_W-1:0] data;
    } ncl_nvm_req_t;

endpackage : ncl_pkg

// ### ncl_crc.sv
// Word-wide CRC accumulator with configurable polynomial and bit order.
`timescale 1ns/1ns
module ncl_crc #(
    parameter int W = 16,
    parameter logic [W-1:0] POLY = 16'h1021,
    parameter logic [W-1:0] INIT = 16'hFFFF,
    parameter bit MSB_FIRST = 1'b1
) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic resetn_in,
    // Control and data
    input wire logic clr_in,
    input wire logic upd_in,
    input wire logic [W-1:0] data_in,
    // Result
    output logic [W-1:0] crc_out
);

    function automatic logic [W-1:0] ncl_crc_step(input logic [W-1:0] c_in,
                                                 input logic [W-1:0] d);
        logic [W-1:0] c;
        logic b;
        c = c_in;
        b = 1'b0;
        for (int i = 0; i < W; i++) begin
            b = MSB_FIRST ? d[W-1-i] : d[i];
            if (c[W-1] ^ b) begin
                c = {c[W-2:0], 1'b0} ^ POLY;
            end else begin
                c = {c[W-2:0], 1'b0};
            end
        end
        return c;
    endfunction : ncl_crc_step

    logic [W-1:0] crc_r;
    logic [W-1:0] base;

    // A clear and an update in one cycle start a fresh sum with this word.
    assign base = clr_in ? INIT : crc_r;
    assign crc_out = crc_r;

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            crc_r <= INIT;
        end else if (upd_in) begin
            crc_r <= ncl_crc_step(base, data_in);
        end else if (clr_in) begin
            crc_r <= INIT;
        end
    end

endmodule : ncl_crc

// ### ncl_loader.sv
// Configuration loader: nonvolatile copy-in with CRC check, store-all, scratchpad.
//
// Notes on behaviour
// - Store-all writes every setting plus a freshly computed CRC to nonvolatile memory.
// - After reset or reload the settings are copied from nonvolatile memory into RAM.
// - During the copy the CRC is recomputed and compared with the stored one.
// - On CRC mismatch rails stay off until a later load finds a matching CRC in memory.
// - User scratchpad words are stored and returned but steer nothing.
// - Configuration writes in the idle state take effect at once, whatever the scratchpad signature; during a load or store they are ignored.
// - The block answers the global bus address 0x5B regardless of address pins.
`timescale 1ns/1ns
module ncl_loader
    import ncl_pkg::*;
#(
    parameter logic [NCL_DATA_W-1:0] CRC_POLY = ncl_pkg::NCL_CRC_POLY,
    parameter logic [NCL_DATA_W-1:0] CRC_INIT = ncl_pkg::NCL_CRC_INIT,
    parameter bit CRC_MSB_FIRST = 1'b1
) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic resetn_in,
    // Commands
    input wire logic store_all_in,
    input wire logic reload_in,
    input wire logic rails_req_in,
    // Nonvolatile memory port
    output ncl_pkg::ncl_nvm_req_t nvm_req_out,
    input wire logic nvm_busy_in,
    input wire logic [ncl_pkg::NCL_DATA_W-1:0] nvm_rd_data_in,
    // Configuration register access
    input wire logic cfg_wr_in,
    input wire logic [ncl_pkg::NCL_IDX_W-1:0] cfg_idx_in,
    input wire logic [ncl_pkg::NCL_DATA_W-1:0] cfg_wdata_in,
    output logic [ncl_pkg::NCL_DATA_W-1:0] cfg_rdata_out,
    output logic [ncl_pkg::NCL_CFG_WORDS*ncl_pkg::NCL_DATA_W-1:0] cfg_all_out,
    // User scratchpad access
    input wire logic user_wr_in,
    input wire logic [ncl_pkg::NCL_PAGE_W-1:0] user_page_in,
    input wire logic [ncl_pkg::NCL_DATA_W-1:0] user_wdata_in,
    output logic [ncl_pkg::NCL_DATA_W-1:0] user_rdata_out,
    // Bus address match
    input wire logic [ncl_pkg::NCL_BUS_ADDR_W-1:0] bus_addr_in,
    input wire logic [ncl_pkg::NCL_ASEL_W-1:0] asel_pin_in,
    output logic addr_hit_out,
    // Status
    output logic rails_en_out,
    output logic crc_ok_out,
    output logic crc_err_out,
    output logic busy_out
);
    import ncl_pkg::*;

    ncl_state_t state_r;
    ncl_state_t state_nxt;
    logic [NCL_ADDR_W-1:0] idx_r;
    logic [NCL_ADDR_W-1:0] idx_nxt;
    logic [NCL_DATA_W-1:0] cfg_r [NCL_CFG_WORDS];
    logic [NCL_DATA_W-1:0] user_r [NCL_USER_PAGES];
    ncl_nvm_req_t nvm_req_r;
    ncl_nvm_req_t nvm_req_nxt;
    logic crc_clr;
    logic crc_upd;
    logic [NCL_DATA_W-1:0] crc_data;
    logic [NCL_DATA_W-1:0] crc_val;
    logic at_crc;
    logic cap_word;
    logic crc_ok_r;
    logic crc_err_r;
    logic rails_en_r;
    logic busy_r;
    logic addr_hit_r;
    logic [NCL_ASEL_W-1:0] asel_meta_r;
    logic [NCL_ASEL_W-1:0] asel_sync_r;
    logic [NCL_DATA_W-1:0] cfg_rdata_r;
    logic [NCL_DATA_W-1:0] user_rdata_r;

    assign at_crc = (idx_r == NCL_CRC_NVM_ADDR);
    assign cap_word = (state_r == NCL_LD_CAP) && !at_crc;

    ncl_crc #(
        .W(NCL_DATA_W),
        .POLY(CRC_POLY),
        .INIT(CRC_INIT),
        .MSB_FIRST(CRC_MSB_FIRST)
    ) u_crc (
        .core_clk_in(core_clk_in),
        .resetn_in(resetn_in),
        .clr_in(crc_clr),
        .upd_in(crc_upd),
        .data_in(crc_data),
        .crc_out(crc_val)
    );

    // Sequencer: load path, store path and idle.
    always_comb begin
        state_nxt = state_r;
        idx_nxt = idx_r;
        nvm_req_nxt = '0;
        nvm_req_nxt.addr = idx_r;
        crc_clr = 1'b0;
        crc_upd = 1'b0;
        crc_data = nvm_rd_data_in;
        case (state_r)
            NCL_LD_REQ: begin
                if (!nvm_busy_in) begin
                    nvm_req_nxt.rd = 1'b1;
                    state_nxt = NCL_LD_WAIT;
                end
            end
            NCL_LD_WAIT: begin
                state_nxt = NCL_LD_CAP;
            end
            NCL_LD_CAP: begin
                if (!at_crc) begin
                    crc_upd = 1'b1;
                    idx_nxt = idx_r + NCL_IDX_STEP;
                    state_nxt = NCL_LD_REQ;
                end else begin
                    state_nxt = NCL_RUN;
                end
            end
            NCL_ST_WR: begin
                if (!nvm_busy_in) begin
                    nvm_req_nxt.wr = 1'b1;
                    if (!at_crc) begin
                        nvm_req_nxt.data = cfg_r[idx_r[NCL_IDX_W-1:0]];
                        crc_data = cfg_r[idx_r[NCL_IDX_W-1:0]];
                        crc_upd = 1'b1;
                        idx_nxt = idx_r + NCL_IDX_STEP;
                    end else begin
                        // The same store writes the CRC, then reads it all back.
                        nvm_req_nxt.data = crc_val;
                        crc_clr = 1'b1;
                        idx_nxt = NCL_IDX_ZERO;
                        state_nxt = NCL_LD_REQ;
                    end
                end
            end
            NCL_RUN: begin
                if (reload_in) begin
                    crc_clr = 1'b1;
                    idx_nxt = NCL_IDX_ZERO;
                    state_nxt = NCL_LD_REQ;
                end else if (store_all_in) begin
                    crc_clr = 1'b1;
                    idx_nxt = NCL_IDX_ZERO;
                    state_nxt = NCL_ST_WR;
                end
            end
            default: begin
                state_nxt = NCL_RUN;
            end
        endcase
    end

    // Reset starts a load straight away, so rails wait for a good check.
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_r <= NCL_LD_REQ;
            idx_r <= NCL_IDX_ZERO;
            nvm_req_r <= '0;
            busy_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            idx_r <= idx_nxt;
            nvm_req_r <= nvm_req_nxt;
            busy_r <= (state_nxt != NCL_RUN);
        end
    end

    // Result of the compare; only a full matching load sets it.
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            crc_ok_r <= 1'b0;
            crc_err_r <= 1'b0;
        end else if (state_r == NCL_RUN && reload_in) begin
            crc_ok_r <= 1'b0;
            crc_err_r <= 1'b0;
        end else if (state_r == NCL_LD_CAP && at_crc) begin
            crc_ok_r <= (crc_val == nvm_rd_data_in);
            crc_err_r <= (crc_val != nvm_rd_data_in);
        end
    end

    // Rails stay off whenever the last check failed.
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rails_en_r <= 1'b0;
        end else begin
            rails_en_r <= rails_req_in && crc_ok_r && !(state_r == NCL_RUN && reload_in);
        end
    end

    // Working settings: host writes are ignored while a load or store runs,
    // since they would break the match between RAM and the stored CRC.
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            for (int i = 0; i < NCL_CFG_WORDS; i++) begin
                cfg_r[i] <= NCL_WORD_ZERO;
            end
        end else if (cap_word) begin
            cfg_r[idx_r[NCL_IDX_W-1:0]] <= nvm_rd_data_in;
        end else if (cfg_wr_in && state_r == NCL_RUN) begin
            cfg_r[cfg_idx_in] <= cfg_wdata_in;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NCL_CFG_WORDS; g++) begin : g_cfg_out
            assign cfg_all_out[g*NCL_DATA_W +: NCL_DATA_W] = cfg_r[g];
        end
    endgenerate

    // Scratchpad: storage only, nothing else reads it.
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            for (int i = 0; i < NCL_USER_PAGES; i++) begin
                user_r[i] <= NCL_WORD_ZERO;
            end
        end else if (user_wr_in) begin
            user_r[user_page_in] <= user_wdata_in;
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cfg_rdata_r <= NCL_WORD_ZERO;
            user_rdata_r <= NCL_WORD_ZERO;
        end else begin
            cfg_rdata_r <= cfg_r[cfg_idx_in];
            user_rdata_r <= user_r[user_page_in];
        end
    end

    // Address pins come from the board, so they are synchronised first.
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            asel_meta_r <= '0;
            asel_sync_r <= '0;
            addr_hit_r <= 1'b0;
        end else begin
            asel_meta_r <= asel_pin_in;
            asel_sync_r <= asel_meta_r;
            addr_hit_r <= (bus_addr_in == NCL_GLOBAL_ADDR) ||
                          (bus_addr_in == {NCL_BASE_ADDR_HI, asel_sync_r});
        end
    end

    assign nvm_req_out = nvm_req_r;
    assign cfg_rdata_out = cfg_rdata_r;
    assign user_rdata_out = user_rdata_r;
    assign addr_hit_out = addr_hit_r;
    assign rails_en_out = rails_en_r;
    assign crc_ok_out = crc_ok_r;
    assign crc_err_out = crc_err_r;
    assign busy_out = busy_r;

endmodule : ncl_loader

// ### ncl_loader_assertions.sv
// Concurrent checks on the configuration loader ports.
`timescale 1ns/1ns
module ncl_loader_chk
    import ncl_pkg::*;
(
    // Clock, reset and commands
    input wire logic core_clk_in,
    input wire logic resetn_in,
    input wire logic store_all_in,
    input wire logic reload_in,
    input wire logic rails_req_in,
    input wire logic cfg_wr_in,
    input wire logic [ncl_pkg::NCL_IDX_W-1:0] cfg_idx_in,
    input wire logic [ncl_pkg::NCL_DATA_W-1:0] cfg_wdata_in,
    input wire logic user_wr_in,
    input wire logic [ncl_pkg::NCL_BUS_ADDR_W-1:0] bus_addr_in,
    input wire logic nvm_busy_in,
    // Watched outputs
    input wire ncl_pkg::ncl_nvm_req_t nvm_req_out,
    input wire logic [ncl_pkg::NCL_CFG_WORDS*ncl_pkg::NCL_DATA_W-1:0] cfg_all_out,
    input wire logic addr_hit_out,
    input wire logic rails_en_out,
    input wire logic crc_ok_out,
    input wire logic crc_err_out,
    input wire logic busy_out
);
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!resetn_in);
    property p_rails;
        rails_en_out == $past(rails_req_in && crc_ok_out && !(reload_in && !busy_out));
    endproperty
    a_rails: assert property (p_rails) else $error("rails enable without good load");
    property p_excl; !(crc_ok_out && crc_err_out); endproperty
    a_excl: assert property (p_excl) else $error("check result both good and bad");
    property p_rd_pulse; nvm_req_out.rd |=> !nvm_req_out.rd; endproperty
    a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe too long");
    property p_stall; nvm_req_out.rd || nvm_req_out.wr |-> !$past(nvm_busy_in); endproperty
    a_stall: assert property (p_stall) else $error("memory access while stalled");
    property p_store; store_all_in && !busy_out && !reload_in
        |-> ##[1:40] nvm_req_out.wr && nvm_req_out.addr == NCL_IDX_ZERO; endproperty
    a_store: assert property (p_store) else $error("store did not start");
    property p_verify; nvm_req_out.wr && nvm_req_out.addr == NCL_CRC_NVM_ADDR
        |-> ##[1:8] nvm_req_out.rd && nvm_req_out.addr == NCL_IDX_ZERO; endproperty
    a_verify: assert property (p_verify) else $error("no reload after store");
    property p_global; bus_addr_in == NCL_GLOBAL_ADDR |=> addr_hit_out; endproperty
    a_global: assert property (p_global) else $error("global address missed");
    property p_user; user_wr_in && !cfg_wr_in && !busy_out && !store_all_in && !reload_in
        |=> $stable(cfg_all_out); endproperty
    a_user: assert property (p_user) else $error("scratchpad changed settings");
    property p_cfg; cfg_wr_in && !busy_out && !reload_in
        |=> cfg_all_out[$past(cfg_idx_in)*NCL_DATA_W +: NCL_DATA_W] == $past(cfg_wdata_in);
    endproperty
    a_cfg: assert property (p_cfg) else $error("setting write not applied");
    c_err: cover property ($rose(crc_err_out));
    c_crc_wr: cover property (nvm_req_out.wr && nvm_req_out.addr == NCL_CRC_NVM_ADDR);
    c_rails: cover property ($rose(rails_en_out));
endmodule : ncl_loader_chk
bind ncl_loader ncl_loader_chk u_chk(.core_clk_in, .resetn_in, .store_all_in, .reload_in,
    .rails_req_in, .cfg_wr_in, .cfg_idx_in, .cfg_wdata_in, .user_wr_in, .bus_addr_in,
    .nvm_busy_in, .nvm_req_out, .cfg_all_out, .addr_hit_out, .rails_en_out, .crc_ok_out,
    .crc_err_out, .busy_out);

// ### ncl_nvm_model.sv
// Behavioural nonvolatile memory facing the loader.
`timescale 1ns/1ns
module ncl_nvm_model
    import ncl_pkg::*;
(
    // Clock and stall control
    input wire logic core_clk_in,
    input wire logic slow_in,
    // Memory port
    input wire ncl_pkg::ncl_nvm_req_t req_in,
    output logic busy_out,
    output logic [ncl_pkg::NCL_DATA_W-1:0] rd_data_out
);
    logic [NCL_DATA_W-1:0] mem [0:16];
    initial begin
        busy_out = 1'b0;
        rd_data_out = 16'h0000;
    end
    // A slow part stalls every other cycle to exercise the loader's wait.
    always @(posedge core_clk_in) begin
        busy_out <= slow_in & ~busy_out;
    end
    // Data stands one cycle, then flips every cycle so a late sample shows.
    always @(posedge core_clk_in) begin
        if (req_in.rd) begin
            rd_data_out <= mem[req_in.addr];
        end else begin
            rd_data_out <= ~rd_data_out;
        end
    end
    always @(posedge core_clk_in) begin
        if (req_in.wr) begin
            mem[req_in.addr] <= req_in.data;
        end
    end
endmodule : ncl_nvm_model

// ### ncl_loader_bench.sv
// Self-checking bench for the configuration loader.
`timescale 1ns/1ns
module ncl_loader_bench;
    import ncl_pkg::*;
    logic core_clk_in, resetn_in, store_all_in, reload_in, rails_req_in, nvm_busy_in, cfg_wr_in;
    logic user_wr_in, addr_hit_out, rails_en_out, crc_ok_out, crc_err_out, busy_out, slow;
    ncl_nvm_req_t nvm_req_out;
    logic [NCL_DATA_W-1:0] nvm_rd_data_in, cfg_wdata_in, cfg_rdata_out, user_wdata_in;
    logic [NCL_DATA_W-1:0] user_rdata_out;
    logic [NCL_IDX_W-1:0] cfg_idx_in;
    logic [NCL_PAGE_W-1:0] user_page_in;
    logic [NCL_CFG_WORDS*NCL_DATA_W-1:0] cfg_all_out;
    logic [NCL_BUS_ADDR_W-1:0] bus_addr_in;
    logic [NCL_ASEL_W-1:0] asel_pin_in;
    logic [NCL_DATA_W-1:0] exp_cfg [0:15];
    int mismatches, num_checks;
    ncl_loader dut(.core_clk_in, .resetn_in, .store_all_in, .reload_in, .rails_req_in,
        .nvm_req_out, .nvm_busy_in, .nvm_rd_data_in, .cfg_wr_in, .cfg_idx_in, .cfg_wdata_in,
        .cfg_rdata_out, .cfg_all_out, .user_wr_in, .user_page_in, .user_wdata_in,
        .user_rdata_out, .bus_addr_in, .asel_pin_in, .addr_hit_out, .rails_en_out,
        .crc_ok_out, .crc_err_out, .busy_out);
    ncl_nvm_model nvm(.core_clk_in, .slow_in(slow), .req_in(nvm_req_out),
        .busy_out(nvm_busy_in), .rd_data_out(nvm_rd_data_in));
    initial begin
        core_clk_in = 1'b0;
        forever #5 core_clk_in = ~core_clk_in;
    end
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run
    // The reference sum is rebuilt here, independent of the loader's own engine.
    function automatic logic [15:0] crc_calc();
        logic [15:0] c = NCL_CRC_INIT;
        for (int k = 0; k < 16; k++) begin
            for (int b = 15; b >= 0; b--) begin
                c = {c[14:0], 1'b0} ^ ((c[15] ^ exp_cfg[k][b]) ? NCL_CRC_POLY : 16'h0000);
            end
        end
        return c;
    endfunction : crc_calc
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_in);
        #1;
    endtask : tick
    task automatic wait_idle();
        int n = 0;
        tick(1);
        while (busy_out !== 1'b0 && n < 500) begin
            tick(1);
            n++;
        end
        chk("busy", 16'(busy_out), 16'h0000);
        tick(3);
    endtask : wait_idle
    task automatic check_cfg();
        for (int g = 0; g < 16; g++) begin
            chk("cfg", cfg_all_out[g*16 +: 16], exp_cfg[g]);
        end
    endtask : check_cfg
    task automatic t_boot();
        wait_idle();
        chk("ok", 16'(crc_ok_out), 16'h0001);
        check_cfg();
        chk("rails", 16'(rails_en_out), 16'h0001);
        @(posedge core_clk_in) rails_req_in <= 1'b0;
        tick(2);
        chk("rails", 16'(rails_en_out), 16'h0000);
        @(posedge core_clk_in) rails_req_in <= 1'b1;
        tick(2);
    endtask : t_boot
    task automatic t_bad();
        @(posedge core_clk_in) slow <= 1'b1;
        nvm.mem[16] = nvm.mem[16] ^ 16'h0001;
        @(posedge core_clk_in) reload_in <= 1'b1;
        @(posedge core_clk_in) reload_in <= 1'b0;
        wait_idle();
        chk("err", 16'(crc_err_out), 16'h0001);
        chk("rails", 16'(rails_en_out), 16'h0000);
        // A host that rewrites a consistent sum lets the next reload lift the lock.
        nvm.mem[16] = crc_calc();
        @(posedge core_clk_in) reload_in <= 1'b1;
        @(posedge core_clk_in) reload_in <= 1'b0;
        wait_idle();
        chk("ok", 16'(crc_ok_out), 16'h0001);
        chk("rails", 16'(rails_en_out), 16'h0001);
    endtask : t_bad
    task automatic t_store();
        @(posedge core_clk_in) cfg_wr_in <= 1'b1;
        cfg_idx_in <= 4'hF;
        cfg_wdata_in <= 16'h5A5A;
        @(posedge core_clk_in) cfg_wr_in <= 1'b0;
        exp_cfg[15] = 16'h5A5A;
        tick(2);
        check_cfg();
        chk("rdata", cfg_rdata_out, 16'h5A5A);
        @(posedge core_clk_in) store_all_in <= 1'b1;
        @(posedge core_clk_in) store_all_in <= 1'b0;
        wait_idle();
        chk("word", nvm.mem[15], 16'h5A5A);
        chk("sum", nvm.mem[16], crc_calc());
        chk("err", 16'(crc_err_out), 16'h0000);
        chk("rails", 16'(rails_en_out), 16'h0001);
    endtask : t_store
    task automatic t_user();
        // Signature halves, upper then lower, as a host would leave them.
        @(posedge core_clk_in) user_wr_in <= 1'b1;
        user_wdata_in <= 16'h1A84;
        @(posedge core_clk_in) user_page_in <= 1'b1;
        user_wdata_in <= 16'h59F2;
        @(posedge core_clk_in) user_wr_in <= 1'b0;
        tick(2);
        chk("user", user_rdata_out, 16'h59F2);
        @(posedge core_clk_in) user_page_in <= 1'b0;
        tick(2);
        chk("user", user_rdata_out, 16'h1A84);
        check_cfg();
    endtask : t_user
    task automatic t_addr();
        for (int a = 0; a < 8; a++) begin
            @(posedge core_clk_in) asel_pin_in <= 3'(a);
            bus_addr_in <= NCL_GLOBAL_ADDR;
            tick(4);
            chk("global", 16'(addr_hit_out), 16'h0001);
            @(posedge core_clk_in) bus_addr_in <= {NCL_BASE_ADDR_HI, 3'(a)};
            tick(2);
            chk("pins", 16'(addr_hit_out), 16'h0001);
            @(posedge core_clk_in) bus_addr_in <= {NCL_BASE_ADDR_HI, 3'(~a)};
            tick(2);
            chk("other", 16'(addr_hit_out), 16'h0000);
        end
    endtask : t_addr
    initial begin
        {resetn_in, store_all_in, reload_in, cfg_wr_in, user_wr_in, slow} = 6'h00;
        {cfg_idx_in, cfg_wdata_in, user_page_in, user_wdata_in} = '0;
        {bus_addr_in, asel_pin_in} = '0;
        rails_req_in = 1'b1;
        for (int k = 0; k < 16; k++) begin
            exp_cfg[k] = 16'hA000 + 16'(k) * 16'h0111;
            nvm.mem[k] = exp_cfg[k];
        end
        nvm.mem[16] = crc_calc();
        repeat (20) @(posedge core_clk_in);
        resetn_in <= 1'b1;
        t_boot();
        t_bad();
        t_store();
        t_user();
        t_addr();
        complete_run();
    end
    initial begin
        repeat (20000) @(posedge core_clk_in);
        mismatches++;
        complete_run();
    end
endmodule : ncl_loader_bench
